// ===== pkg/pic_map.vh
// Purpose: address map, field ranges and codes of the interrupt controller
// Assumes: byte addresses on a 32-bit APB, one register per aligned word
// Notes:   included by design/pic_top.v
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PIC_A_SOFT    32'h0200_0000
`define PIC_A_CMPLO   32'h0200_4000
`define PIC_A_CMPHI   32'h0200_4004
`define PIC_A_CNTLO   32'h0200_BFF8
`define PIC_A_CNTHI   32'h0200_BFFC
`define PIC_A_PRIO    32'h0C00_0000
`define PIC_A_PEND0   32'h0C00_1000
`define PIC_A_PEND1   32'h0C00_1004
`define PIC_A_EN0     32'h0C00_2000
`define PIC_A_EN1     32'h0C00_2004
`define PIC_A_THR     32'h0C20_0000
`define PIC_A_CLAIM   32'h0C20_0004

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
// priority window: base plus four times the source number
`define PIC_PRIO_MASK 32'hFFFF_FF00
`define PIC_PRIO_IDX  7:2
`define PIC_SOFT_BIT  0
`define PIC_THR_RNG   3:0
`define PIC_ID_RNG    5:0
`define PIC_NO_SRC    6'h00

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
// compare starts at its top so the timer line is quiet after reset
`define PIC_CMP_RST   64'hFFFF_FFFF_FFFF_FFFF
`define PIC_CNT_RST   64'h0000_0000_0000_0000
`define PIC_CNT_STEP  64'h0000_0000_0000_0001
`define PIC_WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// cause codes of the core request, highest first
// ----------------------------------------------------------------
`define PIC_CS_LOC3   3'h0
`define PIC_CS_LOC2   3'h1
`define PIC_CS_LOC1   3'h2
`define PIC_CS_LOC0   3'h3
`define PIC_CS_EXT    3'h4
`define PIC_CS_SOFT   3'h5
`define PIC_CS_TMR    3'h6
`define PIC_CS_NONE   3'h7

`endif

// ===== design/pic_top.v
// Purpose: platform interrupt controller with core-local timer and
//          software interrupt, reached over APB
// Assumes: one clock, synchronous active-low reset, zero-wait APB
// Notes:   external requests and direct lines are level sensitive
//
// Functional notes
// - sixteen priority levels, forty-four external sources beside core lines
// - four direct lines reach the core unarbitrated, fixed priorities
// - external sources arbitrated by programmable priority and threshold
// - sources numbered 1 to 44; DMA 32-34, pins 37-44
// - order: line3, line2, line1, line0, external, software, timer
// - no request or cause reaches the core without the global enable
// - each type also needs its own core enable bit
// - bit 0 written 1 raises software interrupt, 0 clears it
// - compare readable and writable as low and high words
// - timer count readable as low and high words
// - per-source priority word; level 0 disables, 15 highest
// - hardware sets a source's pending bit on its request
// - claim read clears pending bit of the winning source
// - one enable bit per source, freely set and cleared
// - only priority strictly above threshold is forwarded
// - claim read returns best eligible source and clears it
// - claim read gives 0 when nothing eligible is pending
// - writing the source number completes it, rearming it
`timescale 1ns/1ps
`include "pic_map.vh"

module pic_top
#(
  parameter NSRC = 44,
  parameter PW   = 4
)
(
  input  wire              i_clock,
  input  wire              i_resetn,
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [31:0]       i_paddr,
  input  wire [31:0]       i_pwdata,
  output wire [31:0]       o_prdata,
  output wire              o_pready,
  output wire              o_pslverr,
  input  wire [NSRC:1]     i_ext_req,
  input  wire [3:0]        i_direct_core_irq_lines,
  input  wire              i_core_glob_en,
  input  wire              i_core_meie,
  input  wire              i_core_msie,
  input  wire              i_core_mtie,
  input  wire [3:0]        i_core_local_en,
  output wire              o_ext_irq,
  output wire              o_soft_irq,
  output wire              o_timer_irq,
  output wire [3:0]        o_local_irq,
  output wire              o_irq_req,
  output wire [2:0]        o_irq_cause
);

  localparam IW = 6;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [NSRC:1] req_s1_q;
  reg  [NSRC:1] req_s2_q;
  reg  [3:0]    loc_s1_q;
  reg  [3:0]    loc_s2_q;

  always @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      req_s1_q <= {NSRC{1'b0}};
      req_s2_q <= {NSRC{1'b0}};
      loc_s1_q <= 4'h0;
      loc_s2_q <= 4'h0;
    end
    else
    begin
      req_s1_q <= i_ext_req;
      req_s2_q <= req_s1_q;
      loc_s1_q <= i_direct_core_irq_lines;
      loc_s2_q <= loc_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire          setup = i_psel & ~i_penable;
  wire          acc   = i_psel & i_penable;
  wire          wr    = acc & i_pwrite;
  wire [IW-1:0] pidx  = i_paddr[`PIC_PRIO_IDX];

  wire a_soft  = (i_paddr == `PIC_A_SOFT);
  wire a_cmplo = (i_paddr == `PIC_A_CMPLO);
  wire a_cmphi = (i_paddr == `PIC_A_CMPHI);
  wire a_cntlo = (i_paddr == `PIC_A_CNTLO);
  wire a_cnthi = (i_paddr == `PIC_A_CNTHI);
  wire a_pend0 = (i_paddr == `PIC_A_PEND0);
  wire a_pend1 = (i_paddr == `PIC_A_PEND1);
  wire a_en0   = (i_paddr == `PIC_A_EN0);
  wire a_en1   = (i_paddr == `PIC_A_EN1);
  wire a_thr   = (i_paddr == `PIC_A_THR);
  wire a_claim = (i_paddr == `PIC_A_CLAIM);
  // word 0 of the window is reserved: no source is numbered 0
  wire a_prio  = ((i_paddr & `PIC_PRIO_MASK) == `PIC_A_PRIO) &&
                 (pidx != `PIC_NO_SRC) && (pidx <= NSRC);

  wire a_hit = a_soft | a_cmplo | a_cmphi | a_cntlo | a_cnthi |
               a_pend0 | a_pend1 | a_en0 | a_en1 | a_thr |
               a_claim | a_prio;

  // ----------------------------------------------------------------
  // core-local state: software bit, timer, compare
  // ----------------------------------------------------------------
  reg          soft_q;
  reg  [63:0]  cnt_q;
  reg  [63:0]  cmp_q;
  reg  [PW-1:0] thr_q;

  always @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      soft_q <= 1'b0;
      cnt_q  <= `PIC_CNT_RST;
      cmp_q  <= `PIC_CMP_RST;
      thr_q  <= {PW{1'b0}};
    end
    else
    begin
      if (wr && a_soft)
        soft_q <= i_pwdata[`PIC_SOFT_BIT];
      if (wr && a_cmplo)
        cmp_q[31:0] <= i_pwdata;
      if (wr && a_cmphi)
        cmp_q[63:32] <= i_pwdata;
      // a written half wins over the tick of that cycle
      if (wr && a_cntlo)
        cnt_q[31:0] <= i_pwdata;
      else if (wr && a_cnthi)
        cnt_q[63:32] <= i_pwdata;
      else
        cnt_q <= cnt_q + `PIC_CNT_STEP;
      if (wr && a_thr)
        thr_q <= i_pwdata[`PIC_THR_RNG];
    end
  end

  // ----------------------------------------------------------------
  // per-source gateway: priority, enable, pending, in service
  // ----------------------------------------------------------------
  wire [63:0]      pend_w;
  wire [63:0]      en_w;
  wire [64*PW-1:0] prio_w;
  reg  [IW-1:0]    claim_id_q;

  wire claim_go = acc & ~i_pwrite & a_claim &
                  (claim_id_q != `PIC_NO_SRC);
  wire done_go  = wr & a_claim;

  assign pend_w[0]      = 1'b0;
  assign en_w[0]        = 1'b0;
  assign prio_w[PW-1:0] = {PW{1'b0}};

  genvar g;
  generate
    for (g = 1; g < 64; g = g + 1)
    begin : g_src
      if (g <= NSRC)
      begin : g_live
        localparam [IW-1:0] ID = g;
        reg          pend_q;
        reg          busy_q;
        reg          en_q;
        reg [PW-1:0] prio_q;
        wire hit_claim = claim_go && (claim_id_q == ID);
        wire hit_done  = done_go &&
                         (i_pwdata[`PIC_ID_RNG] == ID) &&
                         (i_pwdata[31:IW] == 26'h000_0000);
        wire en_wr = wr && ((g < 32) ? a_en0 : a_en1);

        always @(posedge i_clock)
        begin
          if (!i_resetn)
          begin
            pend_q <= 1'b0;
            busy_q <= 1'b0;
            en_q   <= 1'b0;
            prio_q <= {PW{1'b0}};
          end
          else
          begin
            // a level still high at claim is the request being served
            if (hit_claim)
              pend_q <= 1'b0;
            else if (req_s2_q[g] && !busy_q)
              pend_q <= 1'b1;
            if (hit_claim)
              busy_q <= 1'b1;
            else if (hit_done)
              busy_q <= 1'b0;
            if (en_wr)
              en_q <= i_pwdata[g % 32];
            if (wr && a_prio && (pidx == ID))
              prio_q <= i_pwdata[PW-1:0];
          end
        end

        assign pend_w[g]           = pend_q;
        assign en_w[g]             = en_q;
        assign prio_w[g*PW +: PW]  = prio_q;
      end
      else
      begin : g_none
        assign pend_w[g]           = 1'b0;
        assign en_w[g]             = 1'b0;
        assign prio_w[g*PW +: PW]  = {PW{1'b0}};
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbiter
  // ----------------------------------------------------------------
  reg [IW-1:0] best_id;
  reg [PW-1:0] best_p;
  reg [PW-1:0] cur_p;
  integer      j;

  // scans downward with >= so the lowest number keeps a tie
  always @*
  begin
    best_id = `PIC_NO_SRC;
    best_p  = {PW{1'b0}};
    cur_p   = {PW{1'b0}};
    for (j = NSRC; j >= 1; j = j - 1)
    begin
      cur_p = prio_w[j*PW +: PW];
      if (pend_w[j] && en_w[j] && (cur_p > thr_q) &&
          (cur_p >= best_p))
      begin
        best_id = j[IW-1:0];
        best_p  = cur_p;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, captured in the setup cycle
  // ----------------------------------------------------------------
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = `PIC_WORD_ZERO;
    if (a_soft)
      rd_d[`PIC_SOFT_BIT] = soft_q;
    if (a_cmplo)
      rd_d = cmp_q[31:0];
    if (a_cmphi)
      rd_d = cmp_q[63:32];
    if (a_cntlo)
      rd_d = cnt_q[31:0];
    if (a_cnthi)
      rd_d = cnt_q[63:32];
    if (a_pend0)
      rd_d = pend_w[31:0];
    if (a_pend1)
      rd_d = pend_w[63:32];
    if (a_en0)
      rd_d = en_w[31:0];
    if (a_en1)
      rd_d = en_w[63:32];
    if (a_thr)
      rd_d[PW-1:0] = thr_q;
    if (a_claim)
      rd_d[IW-1:0] = best_id;
    if (a_prio)
      rd_d[PW-1:0] = prio_w[pidx*PW +: PW];
  end

  reg [31:0] prdata_q;
  reg        err_q;

  // the claimed number is frozen at setup; the clear uses it
  always @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      prdata_q   <= `PIC_WORD_ZERO;
      err_q      <= 1'b0;
      claim_id_q <= `PIC_NO_SRC;
    end
    else if (setup)
    begin
      prdata_q   <= rd_d;
      err_q      <= ~a_hit;
      claim_id_q <= best_id;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = acc;
  assign o_pslverr = acc & err_q;

  // ----------------------------------------------------------------
  // core-facing lines and fixed ordering
  // ----------------------------------------------------------------
  reg       ext_q;
  reg       tmr_q;
  reg [3:0] loc_q;
  reg       req_q;
  reg [2:0] cause_q;
  reg [2:0] cause_d;

  wire ext_any = (best_id != `PIC_NO_SRC);
  wire tmr_on  = (cnt_q >= cmp_q);
  wire [3:0] loc_ok = loc_q & i_core_local_en;

  always @*
  begin
    cause_d = `PIC_CS_NONE;
    if (loc_ok[3])
      cause_d = `PIC_CS_LOC3;
    else if (loc_ok[2])
      cause_d = `PIC_CS_LOC2;
    else if (loc_ok[1])
      cause_d = `PIC_CS_LOC1;
    else if (loc_ok[0])
      cause_d = `PIC_CS_LOC0;
    else if (ext_q && i_core_meie)
      cause_d = `PIC_CS_EXT;
    else if (soft_q && i_core_msie)
      cause_d = `PIC_CS_SOFT;
    else if (tmr_q && i_core_mtie)
      cause_d = `PIC_CS_TMR;
    if (!i_core_glob_en)
      cause_d = `PIC_CS_NONE;
  end

  always @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      ext_q   <= 1'b0;
      tmr_q   <= 1'b0;
      loc_q   <= 4'h0;
      req_q   <= 1'b0;
      cause_q <= `PIC_CS_NONE;
    end
    else
    begin
      ext_q   <= ext_any;
      tmr_q   <= tmr_on;
      loc_q   <= loc_s2_q;
      req_q   <= (cause_d != `PIC_CS_NONE);
      cause_q <= cause_d;
    end
  end

  assign o_ext_irq   = ext_q;
  assign o_soft_irq  = soft_q;
  assign o_timer_irq = tmr_q;
  assign o_local_irq = loc_q;
  assign o_irq_req   = req_q;
  assign o_irq_cause = cause_q;

endmodule

// ===== verification/pic_top_assertions.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: zero-wait APB, registered interrupt outputs
// Notes:   bound to every pic_top instance
`timescale 1ns/1ps
module pic_chk (
  input wire        i_clock,
  input wire        i_resetn,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pslverr,
  input wire [3:0]  i_direct_core_irq_lines,
  input wire        i_core_glob_en,
  input wire        i_core_meie,
  input wire [3:0]  i_core_local_en,
  input wire        o_ext_irq,
  input wire        o_soft_irq,
  input wire        o_timer_irq,
  input wire [3:0]  o_local_irq,
  input wire        o_irq_req,
  input wire [2:0]  o_irq_cause
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_line_latency: assert property (
    i_direct_core_irq_lines[0] [*4] |-> o_local_irq[0])
    else $error("direct line not through in three edges");
  a_top_line: assert property (
    o_local_irq[3] && i_core_local_en[3] && i_core_glob_en
    |=> o_irq_cause == 3'h0)
    else $error("line 3 not ranked first");
  a_ext_over_soft: assert property (
    o_ext_irq && i_core_meie && i_core_glob_en && o_local_irq == 4'h0
    |=> o_irq_cause == 3'h4)
    else $error("external not ranked above software and timer");
  a_glob_gate: assert property (
    !i_core_glob_en |=> !o_irq_req)
    else $error("request without global enable");
  a_meie_gate: assert property (
    !i_core_meie |=> o_irq_cause != 3'h4)
    else $error("external cause without its enable");
  a_soft_write: assert property (
    i_psel && i_penable && i_pwrite && i_paddr == 32'h0200_0000
    |=> o_soft_irq == $past(i_pwdata[0]))
    else $error("software bit not following write");
  a_beyond_last: assert property (
    i_psel && i_penable && i_paddr == 32'h0C00_00B4 |-> o_pslverr)
    else $error("priority of source 45 accepted");
  a_timer_holds: assert property (
    !i_psel [*2] ##0 o_timer_irq |=> o_timer_irq)
    else $error("timer line dropped while count rising");
endmodule

bind pic_top pic_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pslverr(o_pslverr),
  .i_direct_core_irq_lines(i_direct_core_irq_lines),
  .i_core_glob_en(i_core_glob_en), .i_core_meie(i_core_meie),
  .i_core_local_en(i_core_local_en), .o_ext_irq(o_ext_irq),
  .o_soft_irq(o_soft_irq), .o_timer_irq(o_timer_irq),
  .o_local_irq(o_local_irq), .o_irq_req(o_irq_req),
  .o_irq_cause(o_irq_cause));

// ===== verification/pic_src_model.sv
// Purpose: peripheral side holding level interrupt requests
// Assumes: a source drops its line once software services it
// Notes:   raise and done are one-cycle commands from the bench
`timescale 1ns/1ps
module pic_src_model (
  input  wire         i_clock,
  input  wire         i_resetn,
  input  wire [44:1]  i_raise,
  input  wire [6:0]   i_done,
  output logic [44:1] o_req
);
  // ----------------------------------------------------------------
  // request lines
  // ----------------------------------------------------------------
  logic [44:0] drop;
  assign drop = {44'h0, i_done[6]} << i_done[5:0];
  always @(posedge i_clock)
    if (!i_resetn)
      o_req <= '0;
    else
      // held until serviced, so a slow service still sees the line
      o_req <= (o_req | i_raise) & ~drop[44:1];
endmodule

// ===== verification/tb.sv
// Purpose: directed register and priority tests of the controller
// Assumes: zero-wait APB slave, level requests from the source model
// Notes:   core enables and local lines are driven here directly
`timescale 1ns/1ps
`include "pic_map.vh"
module tb;
  logic        clk, rstn, psel, pen, pwr, ge, meie, msie, mtie;
  logic        prdy, perr, xirq, sirq, tirq, req, e;
  logic [31:0] padr, pwd, prd, q, a;
  logic [3:0]  loc, len, lirq;
  logic [2:0]  cause;
  logic [44:1] raise, ext;
  logic [6:0]  done;
  int          miscompares, num_checks;

  pic_top u_dut (.i_clock(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_ext_req(ext), .i_direct_core_irq_lines(loc),
    .i_core_glob_en(ge), .i_core_meie(meie), .i_core_msie(msie),
    .i_core_mtie(mtie), .i_core_local_en(len), .o_ext_irq(xirq),
    .o_soft_irq(sirq), .o_timer_irq(tirq), .o_local_irq(lirq),
    .o_irq_req(req), .o_irq_cause(cause));
  pic_src_model u_src (.i_clock(clk), .i_resetn(rstn), .i_raise(raise),
    .i_done(done), .o_req(ext));

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // leading edge keeps a released strobe from being raised in one step
  task automatic bus(input [31:0] ad, d, input w);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pen, padr, pwd, pwr} <= {2'b10, ad, d, w};
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1)
    begin
      miscompares++;
      report_and_stop();
    end
    q = prd;
    e = perr;
    {psel, pen} <= 2'b00;
  endtask

  task automatic rc(input [31:0] ad, exp, input string nm);
    bus(ad, 32'h0000_0000, 1'b0);
    chk(nm, q, exp);
  endtask

  function automatic [31:0] pa(input int n);
    return `PIC_A_PRIO + 32'(4 * n);
  endfunction

  task automatic cpl(input [5:0] id);
    wt(1);
    done <= {1'b1, id};
    wt(1);
    done <= 7'h00;
    wt(4);
    bus(`PIC_A_CLAIM, {26'h0, id}, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rstn, psel, pen, pwr, ge, meie, msie, mtie} = 8'h00;
    {padr, pwd, loc, len, raise, done} = '0;
    miscompares = 0;
    num_checks = 0;
    wt(8);
    rstn <= 1'b1;
    rc(`PIC_A_CMPLO, 32'hFFFF_FFFF, "cmp_lo");
    bus(`PIC_A_CMPHI, 32'h0000_1234, 1'b1);
    rc(`PIC_A_CMPHI, 32'h0000_1234, "cmp_hi");
    bus(`PIC_A_CNTLO, 32'h0000_0000, 1'b0);
    a = q;
    bus(`PIC_A_CNTLO, 32'h0000_0000, 1'b0);
    chk("cnt_step", q - a, 32'h0000_0003);
    bus(`PIC_A_CNTHI, 32'h0000_0007, 1'b1);
    rc(`PIC_A_CNTHI, 32'h0000_0007, "cnt_hi");
    {ge, mtie} <= 2'b11;
    bus(`PIC_A_CMPHI, 32'h0000_0000, 1'b1);
    wt(3);
    #1 chk("tmr_on", tirq, 1);
    chk("tmr_cause", cause, 6);
    bus(`PIC_A_CMPHI, 32'h0000_0008, 1'b1);
    wt(3);
    #1 chk("tmr_off", tirq, 0);
    $display("test timer done");
    {mtie, msie} <= 2'b01;
    bus(`PIC_A_SOFT, 32'h0000_0001, 1'b1);
    wt(3);
    #1 chk("soft_cause", cause, 5);
    chk("soft_bit", sirq, 1);
    bus(pa(5), 32'h0000_0002, 1'b1);
    bus(pa(33), 32'h0000_00F3, 1'b1);
    bus(pa(37), 32'h0000_00F3, 1'b1);
    bus(pa(40), 32'h0000_00F3, 1'b1);
    rc(pa(33), 32'h0000_0003, "prio_bits");
    rc(pa(45), 32'h0000_0000, "prio_45");
    chk("prio_45_err", e, 1);
    bus(`PIC_A_THR, 32'h0000_0002, 1'b1);
    bus(`PIC_A_EN0, 32'h0000_0020, 1'b1);
    bus(`PIC_A_EN1, 32'h0000_0122, 1'b1);
    rc(`PIC_A_EN1, 32'h0000_0122, "en_hi");
    // sources 5, 33, 37 and 40
    raise <= 44'h091_0000_0010;
    wt(1);
    raise <= '0;
    meie <= 1'b1;
    wt(3);
    rc(`PIC_A_PEND0, 32'h0000_0020, "pend_lo");
    rc(`PIC_A_PEND1, 32'h0000_0122, "pend_hi");
    wt(1);
    #1 chk("ext_cause", cause, 4);
    chk("ext_line", xirq, 1);
    rc(`PIC_A_CLAIM, 32'd33, "tie_low");
    rc(`PIC_A_CLAIM, 32'd37, "claim_2");
    rc(`PIC_A_CLAIM, 32'd40, "claim_3");
    rc(`PIC_A_CLAIM, 32'd0, "at_thr");
    rc(`PIC_A_PEND1, 32'h0000_0000, "claimed");
    cpl(6'd33);
    raise <= 44'h001_0000_0000;
    wt(1);
    raise <= '0;
    wt(6);
    rc(`PIC_A_CLAIM, 32'd33, "rearmed");
    bus(pa(5), 32'h0000_000F, 1'b1);
    rc(`PIC_A_CLAIM, 32'd5, "prio_15");
    $display("test external done");
    len <= 4'hF;
    loc <= 4'b1001;
    wt(6);
    #1 chk("loc3_first", cause, 0);
    chk("loc_line", lirq, 4'b1001);
    wt(1);
    loc <= 4'b0001;
    wt(6);
    #1 chk("loc0", cause, 3);
    wt(1);
    len <= 4'h0;
    wt(3);
    #1 chk("loc_masked", cause, 5);
    wt(1);
    ge <= 1'b0;
    wt(3);
    #1 chk("glob_off", req, 0);
    bus(`PIC_A_SOFT, 32'h0000_0000, 1'b1);
    wt(1);
    #1 chk("soft_clr", sirq, 0);
    $display("test local done");
    report_and_stop();
  end
endmodule
